/* File: core/rscp_link.sv */
// Purpose: Serial engine: power pulse, fly-back gap, command bits, response bits
// Assumes: One command at a time, started by a one-cycle start pulse
// Notes: Response sampled at the end of each bit period
`timescale 1ns/1ns
`default_nettype none
`include "rscp_regs.svh"
module rscp_link #(
    parameter int PULSE_CYC = `RSCP_PULSE_CYC,
    parameter int GAP_CYC = `RSCP_GAP_CYC,
    parameter int BIT_CYC = `RSCP_BIT_CYC,
    parameter int CMD_BITS = 5,
    parameter int RESP_BITS = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic fly_dis,
    input wire logic [4:0] cmd,
    input wire logic is_read,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    output logic done,
    output logic [15:0] resp
);
    import rscp_pkg::*;

    rscp_lk_t s_r;
    rscp_lk_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            LK_IDLE: begin
                if (start) begin
                    s_nxt.st = LK_PULSE;
                    s_nxt.rd = is_read;
                    s_nxt.resp_phase = 1'b0;
                    s_nxt.cnt = 16'(PULSE_CYC - 1);
                    s_nxt.shreg = {cmd, 11'h000};
                    s_nxt.pin_o = 1'b1;
                    s_nxt.pin_oe = 1'b1;
                end
            end
            LK_PULSE: begin
                if (s_r.cnt == 16'h0000) begin
                    s_nxt.st = LK_GAP;
                    s_nxt.cnt = 16'(GAP_CYC - 1);
                    s_nxt.pin_o = 1'b0;
                    s_nxt.pin_oe = fly_dis;
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            LK_GAP: begin
                if (s_r.cnt == 16'h0000) begin
                    s_nxt.st = LK_XFER;
                    s_nxt.cnt = 16'(BIT_CYC - 1);
                    s_nxt.bitn = 5'h00;
                    s_nxt.pin_o = s_r.shreg[15];
                    s_nxt.pin_oe = 1'b1;
                    s_nxt.shreg = {s_r.shreg[14:0], 1'b0};
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            LK_XFER: begin
                if (s_r.cnt != 16'h0000) begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end else if (s_r.resp_phase) begin
                    s_nxt.shreg = {s_r.shreg[14:0], pin_i};
                    s_nxt.cnt = 16'(BIT_CYC - 1);
                    s_nxt.bitn = s_r.bitn + 5'h01;
                    if (s_r.bitn == 5'(RESP_BITS - 1)) begin
                        s_nxt.st = LK_IDLE;
                        s_nxt.done = 1'b1;
                    end
                end else if (s_r.bitn == 5'(CMD_BITS - 1)) begin
                    s_nxt.pin_o = 1'b0;
                    s_nxt.pin_oe = 1'b0;
                    s_nxt.cnt = 16'(BIT_CYC - 1);
                    s_nxt.bitn = 5'h00;
                    if (s_r.rd) begin
                        s_nxt.resp_phase = 1'b1;
                    end else begin
                        s_nxt.st = LK_IDLE;
                        s_nxt.done = 1'b1;
                    end
                end else begin
                    s_nxt.pin_o = s_r.shreg[15];
                    s_nxt.shreg = {s_r.shreg[14:0], 1'b0};
                    s_nxt.cnt = 16'(BIT_CYC - 1);
                    s_nxt.bitn = s_r.bitn + 5'h01;
                end
            end
            default: s_nxt.st = LK_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin_o = s_r.pin_o;
    assign pin_oe = s_r.pin_oe;
    assign done = s_r.done;
    assign resp = s_r.shreg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_pulse_end;
        s_r.st == LK_PULSE && s_r.cnt == 16'h0000;
    endsequence

    property p_pulse_high;
        s_r.st == LK_IDLE && start |=> pin_oe && pin_o;
    endproperty
    a_pulse_high: assert property (p_pulse_high) else $error("power pulse not driven high");

    property p_flyback_open;
        s_pulse_end and !fly_dis |=> !pin_oe [*2];
    endproperty
    a_flyback_open: assert property (p_flyback_open) else $error("fly-back gap not open");

    property p_driven_low;
        s_pulse_end and fly_dis |=> pin_oe && !pin_o;
    endproperty
    a_driven_low: assert property (p_driven_low) else $error("pulse not driven low");

endmodule
`default_nettype wire

/* File: core/rscp_pkg.sv */
// Purpose: Types of the remote sensor command port
// Assumes: Nothing beyond the register header
// Notes: State of each module is one packed struct
package rscp_pkg;

    typedef enum logic [1:0] {LK_IDLE, LK_PULSE, LK_GAP, LK_XFER} rscp_lk_state_t;

    typedef struct packed {
        rscp_lk_state_t st;
        logic rd;
        logic resp_phase;
        logic [15:0] cnt;
        logic [4:0] bitn;
        logic [15:0] shreg;
        logic pin_o;
        logic pin_oe;
        logic done;
    } rscp_lk_t;

    typedef struct packed {
        logic [4:0] cmd;
        logic fly_dis;
        logic [2:0] en;
        logic [15:0] resp;
        logic [7:0] rdata;
        logic start;
        logic busy;
        logic [1:0] sel;
    } rscp_top_t;

endpackage

/* File: core/rscp_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the remote sensor port
// Assumes: 250 MHz system clock
// Notes: Link timing figures are plain defaults for the serial link
`ifndef RSCP_REGS_SVH
`define RSCP_REGS_SVH

// Register locations
`define RSCP_SFR_CMD 8'hFC
`define RSCP_ADDR_FLY 16'h210C
`define RSCP_ADDR_RESP_HI 16'h2602
`define RSCP_ADDR_RESP_LO 16'h2603
`define RSCP_ADDR_EN 16'h2709

// Field positions
`define RSCP_BIT_FLY 3
`define RSCP_BIT_EN_LO 3
`define RSCP_BIT_EN_HI 5
`define RSCP_BIT_CMD_RD 4
`define RSCP_BIT_SEL_HI 3
`define RSCP_BIT_SEL_LO 2

// Reset values
`define RSCP_CMD_RST 5'h00
`define RSCP_FLY_RST 1'h0
`define RSCP_EN_RST 3'h0
`define RSCP_RESP_RST 16'h0000

// Timing in ns and derived cycle counts
`define RSCP_CLK_NS 4
`define RSCP_PULSE_NS 1000
`define RSCP_GAP_NS 1000
`define RSCP_BIT_NS 400
`define RSCP_PULSE_CYC ((`RSCP_PULSE_NS + `RSCP_CLK_NS - 1) / `RSCP_CLK_NS)
`define RSCP_GAP_CYC ((`RSCP_GAP_NS + `RSCP_CLK_NS - 1) / `RSCP_CLK_NS)
`define RSCP_BIT_CYC ((`RSCP_BIT_NS + `RSCP_CLK_NS - 1) / `RSCP_CLK_NS)

`endif

/* File: core/rscp_top.sv */
// Purpose: Remote sensor command port: command field, enables, fly-back choice, response bytes
// Assumes: Processor register port, one access per cycle, read data one cycle later
// Notes: Command cmd[3:2] picks the interface, cmd[4] marks a read
//
// Overview of operation
// - A non-zero write to the command field while idle sends that command to the selected remote sensor if its interface is enabled.
// - Hardware clears the command field to zero when the command completes.
// - Fly-back enabled: power pulse is followed by an open-circuit interval.
// - Fly-back disabled: the power pulse is driven both high and low.
// - Three enable bits each switch on one interface; all reset to zero.
// - Sixteen-bit read answer appears as two read-only bytes, upper then lower.
`timescale 1ns/1ns
`default_nettype none
`include "rscp_regs.svh"
module rscp_top #(
    parameter int PULSE_CYC = `RSCP_PULSE_CYC,
    parameter int GAP_CYC = `RSCP_GAP_CYC,
    parameter int BIT_CYC = `RSCP_BIT_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cpu_sfr_sel,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic [2:0] link_i,
    output logic [2:0] link_o,
    output logic [2:0] link_oe
);
    import rscp_pkg::*;

    rscp_top_t s_r;
    rscp_top_t s_nxt;
    logic lk_o;
    logic lk_oe;
    logic lk_done;
    logic [15:0] lk_resp;
    logic lk_in;
    logic [1:0] wsel;
    logic wr_cmd;

    assign wsel = cpu_wdata[`RSCP_BIT_SEL_HI:`RSCP_BIT_SEL_LO];
    assign wr_cmd = cpu_wr && cpu_sfr_sel && cpu_addr[7:0] == `RSCP_SFR_CMD;
    assign lk_in = (s_r.sel == 2'h3) ? 1'b0 : link_i[s_r.sel];

    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        // Completion first; a write during busy is dropped so the two never collide
        if (s_r.busy && lk_done) begin
            s_nxt.busy = 1'b0;
            s_nxt.cmd = `RSCP_CMD_RST;
            if (s_r.cmd[`RSCP_BIT_CMD_RD]) begin
                s_nxt.resp = lk_resp;
            end
        end
        if (cpu_wr) begin
            if (wr_cmd) begin
                if (!s_r.busy && cpu_wdata[4:0] != 5'h00) begin
                    s_nxt.sel = wsel;
                    // Disabled or missing interface: finish at once, nothing sent
                    if (wsel != 2'h3 && s_r.en[wsel]) begin
                        s_nxt.cmd = cpu_wdata[4:0];
                        s_nxt.start = 1'b1;
                        s_nxt.busy = 1'b1;
                    end
                end
            end else if (!cpu_sfr_sel && cpu_addr == `RSCP_ADDR_FLY) begin
                s_nxt.fly_dis = cpu_wdata[`RSCP_BIT_FLY];
            end else if (!cpu_sfr_sel && cpu_addr == `RSCP_ADDR_EN) begin
                s_nxt.en = cpu_wdata[`RSCP_BIT_EN_HI:`RSCP_BIT_EN_LO];
            end
        end
        if (cpu_rd) begin
            if (cpu_sfr_sel && cpu_addr[7:0] == `RSCP_SFR_CMD) begin
                s_nxt.rdata = {3'h0, s_r.cmd};
            end else if (cpu_sfr_sel) begin
                s_nxt.rdata = 8'h00;
            end else if (cpu_addr == `RSCP_ADDR_FLY) begin
                s_nxt.rdata = 8'(s_r.fly_dis) << `RSCP_BIT_FLY;
            end else if (cpu_addr == `RSCP_ADDR_EN) begin
                s_nxt.rdata = 8'(s_r.en) << `RSCP_BIT_EN_LO;
            end else if (cpu_addr == `RSCP_ADDR_RESP_HI) begin
                s_nxt.rdata = s_r.resp[15:8];
            end else if (cpu_addr == `RSCP_ADDR_RESP_LO) begin
                s_nxt.rdata = s_r.resp[7:0];
            end else begin
                s_nxt.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    rscp_link #(
        .PULSE_CYC(PULSE_CYC),
        .GAP_CYC(GAP_CYC),
        .BIT_CYC(BIT_CYC),
        .CMD_BITS(5),
        .RESP_BITS(16)
    ) i_rscp_link (
        .clk(clk),
        .arst_n(arst_n),
        .start(s_r.start),
        .fly_dis(s_r.fly_dis),
        .cmd(s_r.cmd),
        .is_read(s_r.cmd[`RSCP_BIT_CMD_RD]),
        .pin_i(lk_in),
        .pin_o(lk_o),
        .pin_oe(lk_oe),
        .done(lk_done),
        .resp(lk_resp)
    );

    // Only the selected and enabled interface sees the engine
    for (genvar i = 0; i < 3; i++) begin : g_pin
        assign link_o[i] = lk_o && s_r.sel == 2'(i) && s_r.en[i];
        assign link_oe[i] = lk_oe && s_r.sel == 2'(i) && s_r.en[i];
    end

    assign cpu_rdata = s_r.rdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_issue;
        wr_cmd && !s_r.busy && cpu_wdata[4:0] != 5'h00 && wsel != 2'h3 && s_r.en[wsel];
    endsequence

    property p_issue;
        s_issue |=> s_r.start && s_r.busy ##1 lk_oe && lk_o;
    endproperty
    a_issue: assert property (p_issue) else $error("command not issued");

    property p_zero_quiet;
        wr_cmd && !s_r.busy && cpu_wdata[4:0] == 5'h00 |=> !s_r.start;
    endproperty
    a_zero_quiet: assert property (p_zero_quiet) else $error("zero write started a command");

    property p_clear_done;
        s_r.busy && lk_done |=> s_r.cmd == 5'h00 && !s_r.busy;
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("command not cleared");

    property p_cmd_hold;
        s_r.busy && !lk_done |=> s_r.cmd == $past(s_r.cmd);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command changed while busy");

    property p_en_gate;
        (link_oe & ~s_r.en) == 3'h0;
    endproperty
    a_en_gate: assert property (p_en_gate) else $error("disabled interface driven");

    property p_resp_load;
        s_r.busy && lk_done && s_r.cmd[4] |=> s_r.resp == $past(lk_resp);
    endproperty
    a_resp_load: assert property (p_resp_load) else $error("response not captured");

    property p_resp_read;
        cpu_rd && !cpu_sfr_sel && cpu_addr == `RSCP_ADDR_RESP_HI
            |=> cpu_rdata == $past(s_r.resp[15:8]);
    endproperty
    a_resp_read: assert property (p_resp_read) else $error("upper response byte wrong");

    property p_resp_low;
        cpu_rd && !cpu_sfr_sel && cpu_addr == `RSCP_ADDR_RESP_LO
            |=> cpu_rdata == $past(s_r.resp[7:0]);
    endproperty
    a_resp_low: assert property (p_resp_low) else $error("lower response byte wrong");

    // Read-only bytes: only a finished read may change them
    property p_resp_hold;
        !(s_r.busy && lk_done) |=> s_r.resp == $past(s_r.resp);
    endproperty
    a_resp_hold: assert property (p_resp_hold) else $error("response changed");

    property p_busy_refuse;
        s_r.busy |=> !s_r.start;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("start while busy");

    property p_idle_quiet;
        !s_r.busy |-> !lk_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("link driven while idle");

    sequence s_drop;
        wr_cmd && !s_r.busy && cpu_wdata[4:0] != 5'h00 && (wsel == 2'h3 || !s_r.en[wsel]);
    endsequence

    property p_drop;
        s_drop |=> !s_r.start && s_r.cmd == 5'h00;
    endproperty
    a_drop: assert property (p_drop) else $error("disabled interface command kept");

    property p_fly_write;
        cpu_wr && !cpu_sfr_sel && cpu_addr == `RSCP_ADDR_FLY
            |=> s_r.fly_dis == $past(cpu_wdata[`RSCP_BIT_FLY]);
    endproperty
    a_fly_write: assert property (p_fly_write) else $error("fly-back choice not stored");

    property p_en_write;
        cpu_wr && !cpu_sfr_sel && cpu_addr == `RSCP_ADDR_EN
            |=> s_r.en == $past(cpu_wdata[`RSCP_BIT_EN_HI:`RSCP_BIT_EN_LO]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable bits not stored");

endmodule
`default_nettype wire

/* File: verif/rscp_sensor.sv */
// Purpose: Behavioural remote sensor on one link lane
// Assumes: Lane timing set by the same cycle counts as the port
// Notes: Line is undriven outside the answer window, so it toggles there
`timescale 1ns/1ns
`default_nettype none
module rscp_sensor #(
    parameter int PULSE_CYC = 4,
    parameter int GAP_CYC = 4,
    parameter int BIT_CYC = 4,
    parameter logic [15:0] RESP = 16'h0000
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pin_i,
    output logic [4:0] got_cmd,
    output logic [7:0] n_cmd,
    output logic gap_oe,
    output logic gap_o
);
    localparam int CB = PULSE_CYC + GAP_CYC;
    localparam int RB = CB + 5 * BIT_CYC;
    localparam int EB = RB + 16 * BIT_CYC;
    int t;
    logic act;
    logic tog;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            act <= 1'b0;
            t <= 0;
            tog <= 1'b0;
            got_cmd <= 5'h00;
            n_cmd <= 8'h00;
            gap_oe <= 1'b0;
            gap_o <= 1'b0;
        end else begin
            tog <= ~tog;
            if (!act && pin_oe && pin_o) begin
                act <= 1'b1;
                t <= 1;
                n_cmd <= n_cmd + 8'h01;
            end else if (act) begin
                t <= t + 1;
                if (t == PULSE_CYC + GAP_CYC / 2) begin
                    gap_oe <= pin_oe;
                    gap_o <= pin_o;
                end
                // Command bits arrive high bit first, taken mid-bit
                if (t >= CB && t < RB && (t - CB) % BIT_CYC == BIT_CYC / 2) begin
                    got_cmd <= {got_cmd[3:0], pin_o};
                end
                if ((t == RB && !got_cmd[4]) || t == EB) begin
                    act <= 1'b0;
                    t <= 0;
                end
            end
        end
    end
    // Answer held for whole bit periods, high bit first
    always_comb begin
        if (act && got_cmd[4] && t >= RB && t < EB) begin
            pin_i = RESP[15 - (t - RB) / BIT_CYC];
        end else begin
            pin_i = tog;
        end
    end
endmodule
`default_nettype wire

/* File: verif/rscp_top_bench.sv */
// Purpose: Self-checking bench of the remote sensor command port
// Assumes: Short link counts of 4 cycles each
// Notes: Register accesses are one-cycle strobes driven 1 ns after the edge
`timescale 1ns/1ns
`default_nettype none
`include "rscp_regs.svh"
module rscp_top_bench;
    localparam int PC = 4;
    localparam logic [2:0][15:0] RV = {16'h8001, 16'h5A3C, 16'hA5C3};
    localparam logic [15:0] FC = {8'h00, `RSCP_SFR_CMD};
    logic clk, arst_n, cpu_sfr_sel, cpu_wr, cpu_rd;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_wdata, cpu_rdata, d;
    logic [2:0] link_i, link_o, link_oe, gap_oe, gap_o;
    logic [4:0] got_cmd [3];
    logic [7:0] n_cmd [3];
    logic [4:0] c;
    int err_total, n_compared, cyc;
    rscp_top #(.PULSE_CYC(PC), .GAP_CYC(PC), .BIT_CYC(PC)) i_rscp_top (.clk(clk),
        .arst_n(arst_n), .cpu_sfr_sel(cpu_sfr_sel), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .link_i(link_i),
        .link_o(link_o), .link_oe(link_oe));
    for (genvar g = 0; g < 3; g++) begin : g_sen
        rscp_sensor #(.PULSE_CYC(PC), .GAP_CYC(PC), .BIT_CYC(PC), .RESP(RV[g])) i_rscp_sensor (
            .clk(clk), .arst_n(arst_n), .pin_o(link_o[g]), .pin_oe(link_oe[g]),
            .pin_i(link_i[g]), .got_cmd(got_cmd[g]), .n_cmd(n_cmd[g]), .gap_oe(gap_oe[g]),
            .gap_o(gap_o[g]));
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic finish_test();
        $display("Counts: %0d mismatches, %0d comparisons", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 430 cycles the sequence needs
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic s, input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        #1 cpu_sfr_sel = s;
        cpu_addr = a;
        cpu_wdata = v;
        cpu_wr = 1'b1;
        @(posedge clk);
        #1 cpu_wr = 1'b0;
    endtask
    task automatic rdc(input logic s, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 cpu_sfr_sel = s;
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(posedge clk);
        #1 cpu_rd = 1'b0;
        @(posedge clk);
        #1 d = cpu_rdata;
        check({8'h00, d}, {8'h00, exp});
    endtask
    // Polls the command field; bounded so a stuck command cannot hang
    task automatic wait_idle();
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            #1 cpu_sfr_sel = 1'b1;
            cpu_addr = FC;
            cpu_rd = 1'b1;
            @(posedge clk);
            #1 cpu_rd = 1'b0;
            @(posedge clk);
            #1 d = cpu_rdata;
            if (d === 8'h00) break;
        end
        check({8'h00, d}, 16'h0000);
    endtask
    initial begin
        {cpu_sfr_sel, cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = '0;
        err_total = 0;
        n_compared = 0;
        cyc = 0;
        arst_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 arst_n = 1'b1;
        check({13'h0000, link_oe}, 16'h0000);
        rdc(1'b1, FC, 8'h00);
        rdc(1'b0, `RSCP_ADDR_FLY, 8'h00);
        rdc(1'b0, `RSCP_ADDR_EN, 8'h00);
        rdc(1'b0, `RSCP_ADDR_RESP_HI, 8'h00);
        rdc(1'b0, `RSCP_ADDR_RESP_LO, 8'h00);
        rdc(1'b0, 16'h1234, 8'h00);
        wr(1'b0, `RSCP_ADDR_EN, 8'h38);
        rdc(1'b0, `RSCP_ADDR_EN, 8'h38);
        for (int i = 0; i < 3; i++) begin
            wr(1'b0, `RSCP_ADDR_FLY, (i == 1) ? 8'h08 : 8'h00);
            c = 5'h10 | 5'(i << 2);
            wr(1'b1, FC, {3'h0, c});
            rdc(1'b1, FC, {3'h0, c});
            if (i == 2) wr(1'b1, FC, 8'h01);
            wait_idle();
            rdc(1'b1, FC, 8'h00);
            check({11'h000, got_cmd[i]}, {11'h000, c});
            check({8'h00, n_cmd[i]}, 16'h0001);
            if (i == 1) begin
                check({15'h0000, gap_oe[i]}, 16'h0001);
                check({15'h0000, gap_o[i]}, 16'h0000);
            end else begin
                check({15'h0000, gap_oe[i]}, 16'h0000);
            end
            rdc(1'b0, `RSCP_ADDR_RESP_HI, RV[i][15:8]);
            rdc(1'b0, `RSCP_ADDR_RESP_LO, RV[i][7:0]);
        end
        wr(1'b0, `RSCP_ADDR_RESP_HI, 8'h00);
        rdc(1'b0, `RSCP_ADDR_RESP_HI, RV[2][15:8]);
        wr(1'b1, FC, 8'h01);
        wait_idle();
        check({11'h000, got_cmd[0]}, 16'h0001);
        wr(1'b1, FC, 8'h00);
        rdc(1'b1, FC, 8'h00);
        check({8'h00, n_cmd[0] + n_cmd[1] + n_cmd[2]}, 16'h0004);
        wr(1'b0, `RSCP_ADDR_EN, 8'h30);
        wr(1'b1, FC, 8'h01);
        rdc(1'b1, FC, 8'h00);
        check({8'h00, n_cmd[0]}, 16'h0002);
        wr(1'b1, FC, 8'h0C);
        rdc(1'b1, FC, 8'h00);
        check({8'h00, n_cmd[0] + n_cmd[1] + n_cmd[2]}, 16'h0004);
        wr(1'b0, `RSCP_ADDR_FLY, 8'h08);
        // Second reset with live state: everything must return to zero
        @(posedge clk);
        #1 arst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 arst_n = 1'b1;
        rdc(1'b0, `RSCP_ADDR_EN, 8'h00);
        rdc(1'b0, `RSCP_ADDR_FLY, 8'h00);
        rdc(1'b0, `RSCP_ADDR_RESP_HI, 8'h00);
        rdc(1'b1, FC, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
